// ===== core/sac_pkg.sv
/*
   Constants shared by the converter control block: register addresses,
   field positions, reset values, start-source codes and state encoding.
   Assumes an 8-bit special-function-register bus with byte addresses.
*/
`default_nettype none

package sac_pkg;

   // ------------------------------------------------------------
   // Register addresses and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] SAC_CFG_ADDR = 8'hBC;   // converter_config_reg
   localparam logic [7:0] SAC_CTL_ADDR = 8'hE8;   // converter_control_reg
   localparam logic [7:0] SAC_CFG_RST  = 8'hF8;
   localparam logic [7:0] SAC_CTL_RST  = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SAC_DIV_LSB  = 3;   // sar_clock_divider [7:3]
   localparam int SAC_GAIN_LSB = 0;   // amplifier_gain_select [2:0]
   localparam int SAC_EN_BIT   = 7;
   localparam int SAC_TM_BIT   = 6;
   localparam int SAC_DONE_BIT = 5;
   localparam int SAC_BUSY_BIT = 4;
   localparam int SAC_SRC_LSB  = 2;   // conversion_start_source [3:2]
   localparam int SAC_WIN_BIT  = 1;
   localparam int SAC_LJ_BIT   = 0;

   // ------------------------------------------------------------
   // Start sources and cycle counts
   // ------------------------------------------------------------
   localparam logic [1:0] SAC_SRC_BUSY = 2'h0;   // Write of 1 to busy bit
   localparam logic [1:0] SAC_SRC_T3   = 2'h1;   // Timer 3 overflow
   localparam logic [1:0] SAC_SRC_EXT  = 2'h2;   // External start pin
   localparam logic [1:0] SAC_SRC_T2   = 2'h3;   // Timer 2 overflow
   localparam int SAC_TRACK_SAR_CLKS   = 3;      // Timed tracking length
   localparam int SAC_CONV_SAR_CLKS    = 16;     // Default conversion length

   typedef enum logic [1:0] {SAC_IDLE, SAC_TRACK, SAC_CONV} sac_state_t;

endpackage : sac_pkg

`default_nettype wire

// ===== core/sac_clkdiv.sv
/*
   Conversion-clock divider: one-cycle enable pulse every (div+1) system
   clocks while run is high. Assumes div is stable during a conversion.
*/
`timescale 1ns/100ps
`default_nettype none

module sac_clkdiv
   import sac_pkg::*;
(
   input  wire logic       clk,       // System clock
   input  wire logic       sys_rst,   // Synchronous reset, active high
   input  wire logic       run,       // Divider counts while high
   input  wire logic [4:0] div,       // Division value minus one
   output var  logic       sar_tick   // One-cycle conversion-clock enable
);

   logic [4:0] cnt;

   // ------------------------------------------------------------
   // Counter restarts from zero whenever run drops
   // ------------------------------------------------------------
   wire       wrap     = (cnt == div);
   wire [4:0] next_cnt = wrap ? 5'h00 : 5'(cnt + 5'h01);

   // Counter and tick register
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         cnt      <= 5'h00;
         sar_tick <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         sar_tick <= wrap;
      end
   end

endmodule : sac_clkdiv

`default_nettype wire

// ===== core/sac_ctrl.sv
/*
   Control and configuration registers of the successive-approximation
   converter, with start selection, tracking control and done flags.
   Assumes a core that writes and reads through the special-function
   register bus; timer and start inputs are one-cycle synchronous pulses.
*/
`timescale 1ns/100ps
`default_nettype none

module sac_ctrl
   import sac_pkg::*;
#(
   parameter int CONV_SAR_CLKS = SAC_CONV_SAR_CLKS   // Conversion length
)(
   input  wire logic       clk,                    // System clock
   input  wire logic       sys_rst,                // Synchronous reset, high
   input  wire logic [7:0] sfr_addr,               // Register address
   input  wire logic       sfr_wr,                 // Write strobe
   input  wire logic [7:0] sfr_wdata,              // Write data
   input  wire logic       timer3_ovf,             // Timer 3 overflow pulse
   input  wire logic       timer2_ovf,             // Timer 2 overflow pulse
   input  wire logic       ext_start,              // External start pulse
   input  wire logic       window_hit,             // Window compare event
   output var  logic [7:0] sfr_rdata,              // Read data, one cycle late
   output logic      [4:0] sar_clock_divider,      // Divider field
   output logic      [2:0] amplifier_gain_select,  // Gain field
   output logic            left_justify_select,    // Result justification
   output var  logic       converter_tracking,     // Input held in tracking
   output var  logic       converter_converting,   // Conversion under way
   output logic            conversion_done_flag,   // Complete flag, interrupt
   output logic            window_compare_flag     // Window flag
);

   // Elaboration check: the step counter is five bits wide
   if (CONV_SAR_CLKS < 2 || CONV_SAR_CLKS > 31) begin : g_bad_conv
      $error("CONV_SAR_CLKS out of range");
   end

   localparam logic [4:0] TRACK_LAST = 5'(SAC_TRACK_SAR_CLKS - 1);
   localparam logic [4:0] CONV_LAST  = 5'(CONV_SAR_CLKS - 1);

   logic [7:0] cfg;
   logic       ctl_en, ctl_tm, done_flag, win_flag, ljust;
   logic [1:0] start_src;
   sac_state_t state, next_state;
   logic [4:0] cnt, next_cnt;
   logic       sar_tick;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
      addr_hit = (a == r);
   endfunction : addr_hit

   wire wr_cfg   = sfr_wr && addr_hit(sfr_addr, SAC_CFG_ADDR);
   wire wr_ctl   = sfr_wr && addr_hit(sfr_addr, SAC_CTL_ADDR);
   wire busy_wr  = wr_ctl && sfr_wdata[SAC_BUSY_BIT];
   wire busy_now = (state != SAC_IDLE);

   // Start event from the selected source; a busy write of 0 does nothing
   wire src_evt = (start_src == SAC_SRC_BUSY) ? busy_wr :
                  (start_src == SAC_SRC_T3)   ? timer3_ovf :
                  (start_src == SAC_SRC_EXT)  ? ext_start : timer2_ovf;
   wire start_req = ctl_en && (state == SAC_IDLE) && src_evt;

   wire conv_end = (state == SAC_CONV) && sar_tick && (cnt == CONV_LAST);

   wire [7:0] ctl_view = {ctl_en, ctl_tm, done_flag, busy_now,
                          start_src, win_flag, ljust};
   wire [7:0] next_rdata = addr_hit(sfr_addr, SAC_CFG_ADDR) ? cfg :
                           addr_hit(sfr_addr, SAC_CTL_ADDR) ? ctl_view : 8'h00;

   // ------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------
   // Disabling aborts any conversion; the divider only runs when busy
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         SAC_IDLE: begin
            next_cnt = 5'h00;
            if (start_req) begin
               next_state = ctl_tm ? SAC_TRACK : SAC_CONV;
            end
         end
         SAC_TRACK: begin
            if (sar_tick) begin
               if (cnt == TRACK_LAST) begin
                  next_state = SAC_CONV;
                  next_cnt   = 5'h00;
               end else begin
                  next_cnt = 5'(cnt + 5'h01);
               end
            end
         end
         SAC_CONV: begin
            if (sar_tick) begin
               if (conv_end) begin
                  next_state = SAC_IDLE;
                  next_cnt   = 5'h00;
               end else begin
                  next_cnt = 5'(cnt + 5'h01);
               end
            end
         end
      endcase
      if (!ctl_en) begin
         next_state = SAC_IDLE;
         next_cnt   = 5'h00;
      end
   end

   // Tracking: continuous in mode 0, timed window in mode 1
   wire next_track = ctl_en && (ctl_tm ? (next_state == SAC_TRACK)
                                       : (next_state != SAC_CONV));

   sac_clkdiv u_div (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .run      (busy_now),
      .div      (cfg[SAC_DIV_LSB +: 5]),
      .sar_tick (sar_tick)
   );

   // Sequencer state and status outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state                <= SAC_IDLE;
         cnt                  <= 5'h00;
         converter_tracking   <= 1'b0;
         converter_converting <= 1'b0;
         sfr_rdata            <= 8'h00;
      end else begin
         state                <= next_state;
         cnt                  <= next_cnt;
         converter_tracking   <= next_track;
         converter_converting <= (next_state == SAC_CONV);
         sfr_rdata            <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Registers; hardware set wins over a software clear
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg       <= SAC_CFG_RST;
         ctl_en    <= SAC_CTL_RST[SAC_EN_BIT];
         ctl_tm    <= SAC_CTL_RST[SAC_TM_BIT];
         done_flag <= SAC_CTL_RST[SAC_DONE_BIT];
         start_src <= SAC_CTL_RST[SAC_SRC_LSB +: 2];
         win_flag  <= SAC_CTL_RST[SAC_WIN_BIT];
         ljust     <= SAC_CTL_RST[SAC_LJ_BIT];
      end else begin
         if (wr_cfg) begin
            cfg <= sfr_wdata;
         end
         if (wr_ctl) begin
            ctl_en    <= sfr_wdata[SAC_EN_BIT];
            ctl_tm    <= sfr_wdata[SAC_TM_BIT];
            start_src <= sfr_wdata[SAC_SRC_LSB +: 2];
            ljust     <= sfr_wdata[SAC_LJ_BIT];
         end
         if (conv_end) begin
            done_flag <= 1'b1;
         end else if (wr_ctl) begin
            done_flag <= sfr_wdata[SAC_DONE_BIT];
         end
         if (window_hit) begin
            win_flag <= 1'b1;
         end else if (wr_ctl) begin
            win_flag <= sfr_wdata[SAC_WIN_BIT];
         end
      end
   end

   assign sar_clock_divider     = cfg[SAC_DIV_LSB +: 5];
   assign amplifier_gain_select = cfg[SAC_GAIN_LSB +: 3];
   assign left_justify_select   = ljust;
   assign conversion_done_flag  = done_flag;
   assign window_compare_flag   = win_flag;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_mode0_on;
      ctl_en && !ctl_tm;
   endsequence
   sequence s_done_kept;
      done_flag && !(wr_ctl && !sfr_wdata[SAC_DONE_BIT]);
   endsequence

   AST_TRACK_CONT: assert property (s_mode0_on ##1 (s_mode0_on and !converter_converting) |-> converter_tracking)
      else $error("mode 0 not tracking outside conversion");
   AST_TRACK_EXCL: assert property (!(converter_tracking && converter_converting))
      else $error("tracking during conversion");
   AST_TIMED_TRACK: assert property (start_req && ctl_tm |=> state == SAC_TRACK && converter_tracking)
      else $error("mode 1 start did not begin timed tracking");
   AST_TIMED_ONLY: assert property (ctl_tm && $past(ctl_tm) && converter_tracking |-> state == SAC_TRACK)
      else $error("mode 1 tracking outside timed window");
   AST_DONE_SET: assert property (conv_end |=> done_flag ##0 state == SAC_IDLE)
      else $error("done flag not raised at conversion end");
   AST_DONE_STICKY: assert property (s_done_kept |=> done_flag)
      else $error("done flag dropped without software clear");
   AST_DONE_ZERO: assert property (!done_flag && !conv_end && !(wr_ctl && sfr_wdata[SAC_DONE_BIT]) |=> !done_flag)
      else $error("done flag rose without a finished conversion");
   AST_BUSY_START: assert property (busy_wr && start_src == SAC_SRC_BUSY && ctl_en && state == SAC_IDLE
                                    |=> busy_now ##1 sfr_rdata[SAC_BUSY_BIT] || !addr_hit($past(sfr_addr), SAC_CTL_ADDR))
      else $error("busy write did not start a conversion");
   AST_BUSY_ZERO: assert property (wr_ctl && !sfr_wdata[SAC_BUSY_BIT] && state == SAC_IDLE && !start_req |=> state == SAC_IDLE)
      else $error("busy write of zero had an effect");

endmodule : sac_ctrl

`default_nettype wire

// ===== testbench/sac_tb.sv
/*
   Self-checking bench for the converter control block: register reads and
   writes, busy-bit starts, timed tracking, done-flag handling and aborts.
   Assumes the control block alone, driven directly on its register bus.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import sac_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int N_CONV = 2;   // Short conversion keeps the run brief
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       sfr_wr = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic [2:0] start_pulse = 3'h0;   // Timer 3, external, timer 2
   logic       window_hit = 1'b0;
   wire logic [7:0] sfr_rdata;
   wire logic [4:0] sar_clock_divider;
   wire logic [2:0] amplifier_gain_select;
   wire logic       left_justify_select;
   wire logic       converter_tracking;
   wire logic       converter_converting;
   wire logic       conversion_done_flag;
   wire logic       window_compare_flag;
   int n_fail = 0;
   int num_checks = 0;
   int n_trk, n_conv, n_both;

   sac_ctrl #(.CONV_SAR_CLKS(N_CONV)) sac_ctrl_inst (
      .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .timer3_ovf(start_pulse[0]), .timer2_ovf(start_pulse[2]),
      .ext_start(start_pulse[1]), .window_hit(window_hit), .sfr_rdata(sfr_rdata),
      .sar_clock_divider(sar_clock_divider), .amplifier_gain_select(amplifier_gain_select),
      .left_justify_select(left_justify_select), .converter_tracking(converter_tracking),
      .converter_converting(converter_converting), .conversion_done_flag(conversion_done_flag),
      .window_compare_flag(window_compare_flag));

   // Clock, 8 ns period
   always #4 clk = ~clk;

   // ------------------------------------------------------------
   // Bus tasks and comparison
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge clk);
      sfr_wr    <= 1'b0;
   endtask : wr_reg

   // Read data lands one cycle after the address edge
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      sfr_addr <= a;
      @(posedge clk);
      @(posedge clk);
      #1;
      chk(what, sfr_rdata, exp);
   endtask : rd_chk

   task automatic pulse(input int s);
      @(posedge clk);
      start_pulse[s-1] <= 1'b1;
      @(posedge clk);
      start_pulse[s-1] <= 1'b0;
   endtask : pulse

   // Counts tracking and converting cycles until the done flag rises
   task automatic watch;
      int i;
      n_trk  = 0;
      n_conv = 0;
      n_both = 0;
      for (i = 0; i < 200; i++) begin
         #1;
         if (conversion_done_flag === 1'b1) break;
         n_trk  += int'(converter_tracking);
         n_conv += int'(converter_converting);
         n_both += int'(converter_tracking & converter_converting);
         @(posedge clk);
      end
   endtask : watch

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk("config reset", SAC_CFG_ADDR, SAC_CFG_RST);
      rd_chk("control reset", SAC_CTL_ADDR, SAC_CTL_RST);
      rd_chk("unmapped", 8'h55, 8'h00);
      chk("divider reset", {3'h0, sar_clock_divider}, 8'h1F);
      $display("test reset done");
      // Busy write while disabled must not start
      wr_reg(SAC_CTL_ADDR, 8'h10);
      rd_chk("busy disabled", SAC_CTL_ADDR, 8'h00);
      wr_reg(SAC_CFG_ADDR, 8'h05);
      #1;
      chk("gain", {5'h00, amplifier_gain_select}, 8'h05);
      // Tracking is registered, so it follows the enable one clock later
      wr_reg(SAC_CTL_ADDR, 8'h80);
      @(posedge clk);
      #1;
      chk("track idle", {7'h00, converter_tracking}, 8'h01);
      wr_reg(SAC_CTL_ADDR, 8'h90);
      watch();
      // Divider restart costs one system clock before its first tick
      chk("conv cycles", 8'(n_conv), 8'(N_CONV + 1));
      chk("track overlap", 8'(n_both), 8'h00);
      chk("done set", {7'h00, conversion_done_flag}, 8'h01);
      repeat (20) @(posedge clk);
      #1;
      chk("track after", {7'h00, converter_tracking}, 8'h01);
      rd_chk("done sticky", SAC_CTL_ADDR, 8'hA0);
      wr_reg(SAC_CTL_ADDR, 8'h80);
      rd_chk("done cleared", SAC_CTL_ADDR, 8'h80);
      $display("test busy start done");
      // Busy write with another source selected is ignored
      wr_reg(SAC_CTL_ADDR, 8'h84);
      wr_reg(SAC_CTL_ADDR, 8'h94);
      repeat (3) @(posedge clk);
      #1;
      chk("src busy ignored", {7'h00, converter_converting}, 8'h00);
      rd_chk("src ctl", SAC_CTL_ADDR, 8'h84);
      $display("test source refusal done");
      // Window event and software clear in one cycle: the event wins
      wr_reg(SAC_CTL_ADDR, 8'h81);
      @(posedge clk);
      sfr_wdata  <= 8'h81;
      sfr_wr     <= 1'b1;
      window_hit <= 1'b1;
      @(posedge clk);
      sfr_wr     <= 1'b0;
      window_hit <= 1'b0;
      #1;
      chk("window set wins", {7'h00, window_compare_flag}, 8'h01);
      chk("left justify", {7'h00, left_justify_select}, 8'h01);
      rd_chk("window ctl", SAC_CTL_ADDR, 8'h83);
      wr_reg(SAC_CTL_ADDR, 8'h81);
      #1;
      chk("window cleared", {7'h00, window_compare_flag}, 8'h00);
      $display("test window flag done");
      // Timed tracking for the busy write and every event source
      for (int s = 0; s < 4; s++) begin
         wr_reg(SAC_CTL_ADDR, 8'hC0 | 8'(s << 2));
         @(posedge clk);
         #1;
         chk("no track mode1", {7'h00, converter_tracking}, 8'h00);
         if (s == 0)
            wr_reg(SAC_CTL_ADDR, 8'hD0);
         else
            pulse(s);
         watch();
         // Divider restart adds one system clock ahead of the timed window
         chk("timed track", 8'(n_trk), 8'(SAC_TRACK_SAR_CLKS + 1));
         chk("timed conv", 8'(n_conv), 8'(N_CONV));
         rd_chk("mode1 done", SAC_CTL_ADDR, 8'hE0 | 8'(s << 2));
      end
      $display("test timed tracking done");
      // Disabling mid-conversion aborts without raising done
      wr_reg(SAC_CFG_ADDR, SAC_CFG_RST);
      wr_reg(SAC_CTL_ADDR, 8'h80);
      wr_reg(SAC_CTL_ADDR, 8'h90);
      repeat (10) @(posedge clk);
      #1;
      chk("long conv", {7'h00, converter_converting}, 8'h01);
      wr_reg(SAC_CTL_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk("abort conv", {7'h00, converter_converting}, 8'h00);
      rd_chk("abort done", SAC_CTL_ADDR, 8'h00);
      $display("test abort done");
      end_of_test();
   end

   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #(8 * 5000);
      n_fail++;
      end_of_test();
   end

endmodule : testbench

`default_nettype wire
